// [twd_consts.vh]
`ifndef TWD_CONSTS_VH
`define TWD_CONSTS_VH

// data register selector values held in the address-select register
`define TWD_SEL_IDENTITY     8'h00
`define TWD_SEL_REVISION     8'h01
`define TWD_SEL_FLASH_CTL    8'h02
`define TWD_SEL_FLASH_DATA   8'hb4

// reset values, and the value read back from an unmapped selector
`define TWD_ADDR_RESET       8'h00
`define TWD_FLASH_CTL_RESET  8'h00
`define TWD_FLASH_DATA_RESET 8'h00
`define TWD_UNMAPPED_VALUE   8'h00

// link instruction codes, two bits sent lsb first
`define TWD_INS_DATA_READ    2'h0
`define TWD_INS_DATA_WRITE   2'h1
`define TWD_INS_ADDR_READ    2'h2
`define TWD_INS_ADDR_WRITE   2'h3

// field widths and counts
`define TWD_INS_BITS         2'h2
`define TWD_DATA_BITS        4'h8

`endif

// [twd_pin_sync.v]
`timescale 1ns/1ns
`default_nettype none

// three-stage synchroniser; output follows once stages two and three agree
module twd_pin_sync #(
    parameter WIDTH = 2
) (
    // clock and reset
    input  wire             core_clk,
    input  wire             rst,
    // asynchronous levels in, filtered levels out
    input  wire [WIDTH-1:0] async_in,
    input  wire [WIDTH-1:0] reset_level,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    reg [WIDTH-1:0] stage3;
    integer         i;

    always @(posedge core_clk) begin
        stage1 <= async_in;
        stage2 <= stage1;
        stage3 <= stage2;
        if (rst) begin
            sync_out <= reset_level;
        end else begin
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (stage2[i] == stage3[i]) begin
                    sync_out[i] <= stage3[i];
                end
            end
        end
    end

endmodule // twd_pin_sync

`default_nettype wire

// [twd_debug_regs.v]
`timescale 1ns/1ns
`default_nettype none
`include "twd_consts.vh"

module twd_debug_regs #(
    parameter [7:0] PART_IDENTITY    = 8'h5a, // arbitrary value
    parameter [7:0] SILICON_REVISION = 8'h00  // arbitrary value
) (
    // clock and reset
    input  wire       core_clk,
    input  wire       rst,
    // halt state from the core
    input  wire       core_halted,
    output wire       peripheral_stall,
    output wire       program_stall,
    // shared reset pin, also the link clock
    input  wire       debug_link_clock_pin,
    output wire       user_reset_n,
    // shared port pin, also the link data
    input  wire       port_two_bit_seven_pin_in,
    output wire       port_two_bit_seven_pin_out,
    output wire       port_two_bit_seven_pin_oe,
    // user function of the port pin
    input  wire       user_pin_out,
    input  wire       user_pin_oe,
    output wire       user_pin_in,
    // flash programming side
    output reg  [7:0] flash_prog_control,
    output reg  [7:0] flash_prog_data,
    output reg        flash_control_written,
    output reg        flash_data_written,
    input  wire       flash_data_load,
    input  wire [7:0] flash_data_value
);

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_INS  = 3'h1;
    localparam [2:0] ST_WDAT = 3'h2;
    localparam [2:0] ST_RDAT = 3'h3;

    reg  [7:0] link_address_select;
    reg  [2:0] state;
    reg  [1:0] ins;
    reg  [3:0] bit_cnt;
    reg  [7:0] shreg;
    reg        clk_prev;
    reg        drive_oe;
    reg        drive_bit;
    wire [1:0] synced;
    wire       link_clk;
    wire       link_dat;
    wire       rise;
    wire       fall;

    // data register selected by the address-select register
    function [7:0] read_mux;
        input [7:0] sel;
        input [7:0] ctl;
        input [7:0] dat;
        begin
            case (sel)
                `TWD_SEL_IDENTITY:   read_mux = PART_IDENTITY;
                `TWD_SEL_REVISION:   read_mux = SILICON_REVISION;
                `TWD_SEL_FLASH_CTL:  read_mux = ctl;
                `TWD_SEL_FLASH_DATA: read_mux = dat;
                default:             read_mux = `TWD_UNMAPPED_VALUE;
            endcase
        end
    endfunction

    twd_pin_sync #(
        .WIDTH(2)
    ) u_sync (
        .core_clk    (core_clk),
        .rst         (rst),
        .async_in    ({port_two_bit_seven_pin_in, debug_link_clock_pin}),
        .reset_level (2'h3),
        .sync_out    (synced)
    );

    assign link_clk = synced[0];
    assign link_dat = synced[1];
    // edges count only while halted, so user reset traffic is never decoded
    assign rise = core_halted & link_clk & ~clk_prev;
    assign fall = core_halted & ~link_clk & clk_prev;

    // halted: pins borrowed, everything else stalled
    assign peripheral_stall = core_halted;
    assign program_stall    = core_halted;
    assign user_reset_n     = core_halted ? 1'b1 : debug_link_clock_pin;
    assign user_pin_in      = core_halted ? 1'b1 : port_two_bit_seven_pin_in;
    assign port_two_bit_seven_pin_out = core_halted ? drive_bit : user_pin_out;
    assign port_two_bit_seven_pin_oe  = core_halted ? drive_oe : user_pin_oe;

    always @(posedge core_clk) begin
        if (rst) begin
            clk_prev <= 1'b1;
        end else begin
            clk_prev <= link_clk;
        end
    end

    // link frame: start bit 0, two instruction bits, then eight data bits
    // apart from flash_data_load refreshing flash_prog_data, the register set below has no other write path than this frame
    always @(posedge core_clk) begin
        if (rst) begin
            state                 <= ST_IDLE;
            ins                   <= 2'h0;
            bit_cnt               <= 4'h0;
            shreg                 <= 8'h00;
            drive_oe              <= 1'b0;
            drive_bit             <= 1'b1;
            link_address_select   <= `TWD_ADDR_RESET;
            flash_prog_control    <= `TWD_FLASH_CTL_RESET;
            flash_prog_data       <= `TWD_FLASH_DATA_RESET;
            flash_control_written <= 1'b0;
            flash_data_written    <= 1'b0;
        end else begin
            flash_control_written <= 1'b0;
            flash_data_written    <= 1'b0;
            // the flash engine may refresh the data register; a link write wins
            if (flash_data_load) begin
                flash_prog_data <= flash_data_value;
            end
            if (!core_halted) begin
                state    <= ST_IDLE;
                drive_oe <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (rise && !link_dat) begin
                            state   <= ST_INS;
                            bit_cnt <= 4'h0;
                        end
                    end
                    ST_INS: begin
                        if (rise) begin
                            ins     <= {link_dat, ins[1]};
                            bit_cnt <= bit_cnt + 4'h1;
                            if (bit_cnt == {2'h0, `TWD_INS_BITS} - 4'h1) begin
                                bit_cnt <= 4'h0;
                                // ins[1] still holds the first bit, set for writes
                                if (ins[1]) begin
                                    state <= ST_WDAT;
                                end else if (link_dat) begin
                                    state <= ST_RDAT;
                                    shreg <= link_address_select;
                                end else begin
                                    state <= ST_RDAT;
                                    shreg <= read_mux(link_address_select,
                                                      flash_prog_control,
                                                      flash_prog_data);
                                end
                            end
                        end
                    end
                    ST_WDAT: begin
                        if (rise) begin
                            shreg   <= {link_dat, shreg[7:1]};
                            bit_cnt <= bit_cnt + 4'h1;
                            if (bit_cnt == `TWD_DATA_BITS - 4'h1) begin
                                state <= ST_IDLE;
                                if (ins == `TWD_INS_ADDR_WRITE) begin
                                    // select holds until the next address write
                                    link_address_select <= {link_dat, shreg[7:1]};
                                end else if (link_address_select == `TWD_SEL_FLASH_CTL) begin
                                    flash_prog_control    <= {link_dat, shreg[7:1]};
                                    flash_control_written <= 1'b1;
                                end else if (link_address_select == `TWD_SEL_FLASH_DATA) begin
                                    flash_prog_data    <= {link_dat, shreg[7:1]};
                                    flash_data_written <= 1'b1;
                                end
                                // identity, revision and unmapped: write dropped
                            end
                        end
                    end
                    ST_RDAT: begin
                        // target drives each bit after a falling edge
                        if (fall) begin
                            if (bit_cnt == `TWD_DATA_BITS) begin
                                // release, then swallow the closing rise so that a
                                // last bit of zero lingering in the synchroniser
                                // cannot pose as the next start bit
                                drive_oe <= 1'b0;
                                bit_cnt  <= bit_cnt + 4'h1;
                            end else begin
                                drive_oe  <= 1'b1;
                                drive_bit <= shreg[0];
                                shreg     <= {1'b0, shreg[7:1]};
                                bit_cnt   <= bit_cnt + 4'h1;
                            end
                        end else if (rise && bit_cnt == `TWD_DATA_BITS + 4'h1) begin
                            state <= ST_IDLE;
                        end
                    end
                    default: begin
                        state    <= ST_IDLE;
                        drive_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule // twd_debug_regs

`default_nettype wire

// [twd_debug_regs_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module twd_debug_regs_checker (
    // clock, reset and halt
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       core_halted,
    input wire logic       peripheral_stall,
    input wire logic       program_stall,
    // shared pins
    input wire logic       debug_link_clock_pin,
    input wire logic       user_reset_n,
    input wire logic       port_two_bit_seven_pin_out,
    input wire logic       port_two_bit_seven_pin_oe,
    input wire logic       user_pin_out,
    input wire logic       user_pin_oe,
    input wire logic       user_pin_in,
    // flash programming side
    input wire logic [7:0] flash_prog_control,
    input wire logic [7:0] flash_prog_data,
    input wire logic       flash_control_written,
    input wire logic       flash_data_written,
    input wire logic       flash_data_load,
    input wire logic [7:0] flash_data_value
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_stall_follows_halt: assert property (peripheral_stall == core_halted && program_stall == core_halted)
        else $error("stall outputs differ from halt state");
    a_halt_parks_user: assert property (core_halted |-> user_reset_n && user_pin_in)
        else $error("user pins not parked while halted");
    a_user_owns_pins: assert property (!core_halted |-> port_two_bit_seven_pin_oe == user_pin_oe
        && port_two_bit_seven_pin_out == user_pin_out && user_reset_n == debug_link_clock_pin)
        else $error("shared pins not given to user");
    a_ctl_pulse_once: assert property (flash_control_written |=> !flash_control_written)
        else $error("control write pulse too long");
    a_data_pulse_once: assert property (flash_data_written |=> !flash_data_written)
        else $error("data write pulse too long");
    a_ctl_only_halted: assert property (!$stable(flash_prog_control) && !$past(rst) |-> $past(core_halted))
        else $error("control changed while running");
    a_data_load_taken: assert property (flash_data_load && !core_halted |=> flash_prog_data == $past(flash_data_value))
        else $error("data load lost");
    a_link_quiet_run: assert property (!core_halted ##1 !core_halted |-> !flash_control_written && !flash_data_written)
        else $error("link write while running");
    a_reset_clears: assert property ($fell(rst) |-> flash_prog_control == 8'h00 && flash_prog_data == 8'h00)
        else $error("registers not cleared by reset");
endmodule // twd_debug_regs_checker

bind twd_debug_regs twd_debug_regs_checker twd_debug_regs_checker_inst (
    .core_clk(core_clk), .rst(rst), .core_halted(core_halted), .peripheral_stall(peripheral_stall),
    .program_stall(program_stall), .debug_link_clock_pin(debug_link_clock_pin),
    .user_reset_n(user_reset_n), .port_two_bit_seven_pin_out(port_two_bit_seven_pin_out),
    .port_two_bit_seven_pin_oe(port_two_bit_seven_pin_oe), .user_pin_out(user_pin_out),
    .user_pin_oe(user_pin_oe), .user_pin_in(user_pin_in), .flash_prog_control(flash_prog_control),
    .flash_prog_data(flash_prog_data), .flash_control_written(flash_control_written),
    .flash_data_written(flash_data_written), .flash_data_load(flash_data_load),
    .flash_data_value(flash_data_value));
`default_nettype wire

// [twd_link_host.sv]
`timescale 1ns/1ns
`default_nettype none
module twd_link_host (
    // link pins
    input  wire logic line,
    output var  logic link_clk,
    output var  logic host_oe,
    output var  logic host_d
);
    initial begin
        link_clk = 1'b1; // clock stands high between frames
        host_oe = 1'b0;
        host_d = 1'b1;
    end
    // data changes at the fall, held across the rise
    task automatic send_bit(input logic b);
        link_clk = 1'b0;
        host_oe = 1'b1;
        host_d = b;
        #200;
        link_clk = 1'b1;
        #200;
    endtask
    task automatic frame(input logic [1:0] ins, input logic [7:0] wd, output logic [7:0] rd);
        send_bit(1'b0);
        send_bit(ins[0]);
        send_bit(ins[1]);
        rd = 8'h00;
        if (ins[0]) begin
            for (int i = 0; i < 8; i++) send_bit(wd[i]);
        end else begin
            host_oe = 1'b0; // line turned round to the target
            for (int i = 0; i < 9; i++) begin
                link_clk = 1'b0;
                #200;
                link_clk = 1'b1;
                #190;
                if (i < 8) rd[i] = line;
                #10;
            end
        end
        host_oe = 1'b0;
        #800;
    endtask
endmodule // twd_link_host
`default_nettype wire

// [twd_debug_regs_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`include "twd_consts.vh"
module twd_debug_regs_tb;
    localparam logic [7:0] ID = 8'h6e;  // arbitrary value
    localparam logic [7:0] REV = 8'h21; // arbitrary value
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic       halted = 1'b0;
    logic       u_out = 1'b0;
    logic       u_oe = 1'b0;
    logic       load = 1'b0;
    logic [7:0] load_val = 8'h00;
    logic       link_clk, host_oe, host_d;
    wire logic  tgt_out, tgt_oe, pin;
    wire logic [7:0] ctl, dat;
    wire logic  ctl_wr, dat_wr;
    logic [7:0] n_wr = 8'h00;
    logic [7:0] rd, sel;
    int n_mismatch = 0;
    int total_checks = 0;
    always #25 core_clk = ~core_clk;
    // pulled-up shared data line
    assign pin = tgt_oe ? tgt_out : (host_oe ? host_d : 1'b1);
    twd_debug_regs #(.PART_IDENTITY(ID), .SILICON_REVISION(REV)) twd_debug_regs_inst (
        .core_clk(core_clk), .rst(rst), .core_halted(halted), .peripheral_stall(),
        .program_stall(), .debug_link_clock_pin(link_clk), .user_reset_n(),
        .port_two_bit_seven_pin_in(pin), .port_two_bit_seven_pin_out(tgt_out),
        .port_two_bit_seven_pin_oe(tgt_oe), .user_pin_out(u_out), .user_pin_oe(u_oe),
        .user_pin_in(), .flash_prog_control(ctl), .flash_prog_data(dat),
        .flash_control_written(ctl_wr), .flash_data_written(dat_wr), .flash_data_load(load),
        .flash_data_value(load_val));
    // count write pulses towards the flash engine
    always @(posedge core_clk) begin
        if (ctl_wr || dat_wr) n_wr <= n_wr + 8'h01;
    end
    twd_link_host twd_link_host_inst (
        .line(pin), .link_clk(link_clk), .host_oe(host_oe), .host_d(host_d));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic [1:0] ins, input logic [7:0] wd);
        twd_link_host_inst.frame(ins, wd, rd);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic tick;
        @(posedge core_clk);
        #2;
    endtask
    initial begin
        repeat (4) tick();
        rst = 1'b0;
        u_oe = 1'b1;
        u_out = 1'b1;
        load = 1'b1;
        load_val = 8'h3c;
        tick();
        load = 1'b0;
        u_oe = 1'b0;
        tick();
        check(dat, 8'h3c);
        check(ctl, `TWD_FLASH_CTL_RESET);
        halted = 1'b1;
        repeat (4) tick();
        xfer(`TWD_INS_ADDR_READ, 8'h00);
        check(rd, `TWD_ADDR_RESET);
        xfer(`TWD_INS_DATA_READ, 8'h00);
        check(rd, ID);
        xfer(`TWD_INS_DATA_WRITE, 8'hff);
        xfer(`TWD_INS_DATA_READ, 8'h00);
        check(rd, ID);
        xfer(`TWD_INS_ADDR_WRITE, `TWD_SEL_REVISION);
        xfer(`TWD_INS_DATA_READ, 8'h00);
        check(rd, REV);
        for (int k = 0; k < 2; k++) begin
            sel = k ? `TWD_SEL_FLASH_DATA : `TWD_SEL_FLASH_CTL;
            xfer(`TWD_INS_ADDR_WRITE, sel);
            xfer(`TWD_INS_DATA_WRITE, 8'ha5 ^ sel);
            check(k ? dat : ctl, 8'ha5 ^ sel);
            xfer(`TWD_INS_DATA_READ, 8'h00);
            check(rd, 8'ha5 ^ sel);
        end
        load = 1'b1;
        load_val = 8'h41;
        tick();
        load = 1'b0;
        xfer(`TWD_INS_DATA_READ, 8'h00);
        check(rd, 8'h41);
        xfer(`TWD_INS_ADDR_WRITE, 8'h77);
        xfer(`TWD_INS_DATA_WRITE, 8'h13);
        xfer(`TWD_INS_DATA_READ, 8'h00);
        check(rd, `TWD_UNMAPPED_VALUE);
        check(dat, 8'h41);
        xfer(`TWD_INS_ADDR_READ, 8'h00);
        check(rd, 8'h77);
        xfer(`TWD_INS_ADDR_WRITE, `TWD_SEL_FLASH_CTL);
        tick();
        halted = 1'b0;
        xfer(`TWD_INS_DATA_WRITE, 8'h11);
        check(ctl, 8'ha7);
        check(n_wr, 8'h02);
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        give_verdict();
    end
endmodule // twd_debug_regs_tb
`default_nettype wire
